/* File: soeb_pkg.sv */
/*
 * Constants for the serial output enable bank of a clock synthesizer.
 * Assumes a single 50 MHz core clock and a two-wire serial link whose
 * clock and data pins arrive asynchronously and are sampled by that clock.
 */
// Operation
// - After power-up every clock output is enabled and running.
// - Bytes load from byte 0 upward, each byte most significant bit first.
// - Reserved and unused bits are don't-care and never change any output.
// - Each register bit reads back the value most recently written.
// - An enable bit of one enables its output, zero disables it.
// - A disabled output is held low and stops switching.
// - Byte 0 bits 7 to 0 enable bus clock outputs 0 to 7.
// - Byte 1 enables bus clocks 8-11, two 48 MHz, two reference outputs.
// - Byte 2 bits 7 to 2 enable 66 MHz outputs 0-5; bits 1,0 reserved.
// - Bytes 3 and 4 are wholly reserved and control no output.
// - Bytes written sequentially from lowest; only received bytes update.
// - Command code and byte count are ignored; later bytes load in order.
package soeb_pkg;

    // Bank layout
    localparam int          BANK_BYTES = 5;
    localparam int          BYTE_BITS  = 8;
    localparam logic [2:0]  REG_BUS_LOW      = 3'h0;
    localparam logic [2:0]  REG_MIXED        = 3'h1;
    localparam logic [2:0]  REG_MID          = 3'h2;
    localparam logic [2:0]  REG_RSVD_THREE   = 3'h3;
    localparam logic [2:0]  REG_RSVD_SUPPLY  = 3'h4;

    // Power-up contents: every enable set, reserved bits clear
    localparam logic [7:0]  RST_BUS_LOW      = 8'hFF;
    localparam logic [7:0]  RST_MIXED        = 8'hFF;
    localparam logic [7:0]  RST_MID          = 8'hFC;
    localparam logic [7:0]  RST_RSVD_THREE   = 8'h00;
    localparam logic [7:0]  RST_RSVD_SUPPLY  = 8'h00;
    localparam logic [39:0] BANK_RESET = {RST_RSVD_SUPPLY, RST_RSVD_THREE,
                                          RST_MID, RST_MIXED, RST_BUS_LOW};

    // Field positions inside the mixed byte
    localparam int          MIX_BUS_TOP = 7;
    localparam int          MIX_48_A    = 3;
    localparam int          MIX_48_B    = 2;
    localparam int          MIX_REF_A   = 1;
    localparam int          MIX_REF_B   = 0;
    // Top bit of the 66 MHz field inside the mid byte
    localparam int          MID_66_TOP  = 7;

    // Transfer framing: address, command code, byte count, then data
    localparam logic [5:0]  IDX_ADDR       = 6'h00;
    localparam logic [5:0]  IDX_DATA_FIRST = 6'h03;
    localparam logic [5:0]  IDX_MAX        = 6'h3F;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h69;
    localparam logic        DIR_WRITE      = 1'b0;
    localparam logic        ACK_LEVEL      = 1'b0;

    // Receiver states, Gray along idle, receive, acknowledge
    typedef enum logic [1:0] {
        SOEB_IDLE = 2'b00,
        SOEB_RECV = 2'b01,
        SOEB_ACK  = 2'b11,
        SOEB_SKIP = 2'b10
    } soeb_state_t;

endpackage

/* File: soeb_sync.sv */
/*
 * Two-stage synchroniser with edge detection for asynchronous pins.
 * Assumes inputs change slowly against clock; edges come from stage two.
 */
module soeb_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // Asynchronous pins
    input  wire logic [WIDTH-1:0] asyncIn,
    // Synchronised level and edges
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] last_r;

    // Idle bus is high, so reset to high to avoid a false edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '1;
            sync_r <= '1;
            last_r <= '1;
        end else begin
            meta_r <= asyncIn;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~last_r;
    assign fall  = ~sync_r & last_r;

endmodule

/* File: soeb_bank.sv */
/*
 * Serial output enable bank: two-wire write-only receiver, five-byte
 * enable bank and output gating of the synthesized clocks.
 * Assumes the clock sources are free running and that the link pins are
 * pulled high outside transfers; the link is sampled by the 50 MHz clock.
 */
module soeb_bank #(
    parameter logic [6:0] SLAVE_ADDR = soeb_pkg::SLAVE_ADDR_DEF
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Serial link
    input  wire logic        serialClk,
    input  wire logic        serialDataIn,
    output logic             serialDataOut,
    output logic             serialDataOe,
    // Clock sources
    input  wire logic        busClkSrc,
    input  wire logic        clk48Src,
    input  wire logic        clk66Src,
    input  wire logic        refClkSrc,
    // Gated clock outputs
    output logic             bus_clk_out_0,
    output logic             bus_clk_out_1,
    output logic             bus_clk_out_2,
    output logic             bus_clk_out_3,
    output logic             bus_clk_out_4,
    output logic             bus_clk_out_5,
    output logic             bus_clk_out_6,
    output logic             bus_clk_out_7,
    output logic             bus_clk_out_8,
    output logic             bus_clk_out_9,
    output logic             bus_clk_out_10,
    output logic             bus_clk_out_11,
    output logic             clk48_out_a,
    output logic             clk48_out_b,
    output logic             clk66_out_a,
    output logic             clk66_out_b,
    output logic             clk66_out_c,
    output logic             clk66_out_d,
    output logic             clk66_out_e,
    output logic             clk66_out_f,
    output logic             ref_clk_out_a,
    output logic             ref_clk_out_b,
    // Bank contents for readback
    output logic [39:0]      regBank
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic isBankByte(input logic [5:0] idx);
        isBankByte = (idx >= soeb_pkg::IDX_DATA_FIRST) &&
                     ((idx - soeb_pkg::IDX_DATA_FIRST) <
                      6'(soeb_pkg::BANK_BYTES));
    endfunction

    function automatic logic [2:0] bankIndex(input logic [5:0] idx);
        logic [5:0] off;
        off = idx - soeb_pkg::IDX_DATA_FIRST;
        bankIndex = off[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link sampling

    logic [1:0] pinLvl;
    logic [1:0] pinRise;
    logic [1:0] pinFall;
    logic       sclLvl;
    logic       sdaLvl;
    logic       sclRise;
    logic       sclFall;
    logic       startSeen;
    logic       stopSeen;

    soeb_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock  (clock),
        .rstn   (rstn),
        .asyncIn({serialClk, serialDataIn}),
        .level  (pinLvl),
        .rise   (pinRise),
        .fall   (pinFall)
    );

    assign sclLvl  = pinLvl[1];
    assign sdaLvl  = pinLvl[0];
    assign sclRise = pinRise[1];
    assign sclFall = pinFall[1];
    // Data moving while the clock is high frames a transfer
    assign startSeen = pinFall[0] && sclLvl;
    assign stopSeen  = pinRise[0] && sclLvl;

    ////////////////////////////////////////////////////////////////////////
    // Receiver

    soeb_pkg::soeb_state_t state_r;
    logic [7:0]            shift_r;
    logic [3:0]            bitCnt_r;
    logic [5:0]            byteIdx_r;
    logic                  byteDone;
    logic                  addrOk;
    logic                  bankWe;
    logic [2:0]            wrIdx;

    assign byteDone = (state_r == soeb_pkg::SOEB_RECV) && sclFall &&
                      (bitCnt_r == soeb_pkg::BITS_PER_BYTE);
    assign addrOk   = (shift_r[7:1] == SLAVE_ADDR) &&
                      (shift_r[0] == soeb_pkg::DIR_WRITE);
    // Whole data bytes inside the bank only; extras are acked and dropped
    assign bankWe   = byteDone && isBankByte(byteIdx_r);
    assign wrIdx    = bankIndex(byteIdx_r);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= soeb_pkg::SOEB_IDLE;
        end else if (startSeen) begin
            state_r <= soeb_pkg::SOEB_RECV;
        end else if (stopSeen) begin
            state_r <= soeb_pkg::SOEB_IDLE;
        end else begin
            case (state_r)
                soeb_pkg::SOEB_RECV: begin
                    if (byteDone) begin
                        if (byteIdx_r == soeb_pkg::IDX_ADDR && !addrOk) begin
                            state_r <= soeb_pkg::SOEB_SKIP;
                        end else begin
                            // Command and count bytes are acked, not decoded
                            state_r <= soeb_pkg::SOEB_ACK;
                        end
                    end
                end
                soeb_pkg::SOEB_ACK: begin
                    if (sclFall) begin
                        state_r <= soeb_pkg::SOEB_RECV;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Most significant bit first on each clock rise
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_r  <= 8'h00;
            bitCnt_r <= 4'h0;
        end else if (startSeen || stopSeen) begin
            shift_r  <= 8'h00;
            bitCnt_r <= 4'h0;
        end else if (state_r == soeb_pkg::SOEB_RECV && sclRise) begin
            shift_r  <= {shift_r[6:0], sdaLvl};
            bitCnt_r <= bitCnt_r + 4'h1;
        end else if (state_r == soeb_pkg::SOEB_ACK && sclFall) begin
            bitCnt_r <= 4'h0;
        end
    end

    // Byte position saturates so long transfers never wrap into the bank
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            byteIdx_r <= soeb_pkg::IDX_ADDR;
        end else if (startSeen) begin
            byteIdx_r <= soeb_pkg::IDX_ADDR;
        end else if (byteDone && byteIdx_r != soeb_pkg::IDX_MAX) begin
            byteIdx_r <= byteIdx_r + 6'h01;
        end
    end

    // Acknowledge held from the eighth fall to the ninth
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            serialDataOe <= 1'b0;
        end else if (startSeen || stopSeen) begin
            serialDataOe <= 1'b0;
        end else if (byteDone) begin
            serialDataOe <= (byteIdx_r != soeb_pkg::IDX_ADDR) || addrOk;
        end else if (state_r == soeb_pkg::SOEB_ACK && sclFall) begin
            serialDataOe <= 1'b0;
        end
    end

    assign serialDataOut = soeb_pkg::ACK_LEVEL;

    ////////////////////////////////////////////////////////////////////////
    // Enable bank

    logic [7:0] bank_r [soeb_pkg::BANK_BYTES];
    logic       seenWrite_r;

    // Reserved bits are stored for readback only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < soeb_pkg::BANK_BYTES; i++) begin
                bank_r[i] <= soeb_pkg::BANK_RESET[i*8 +: 8];
            end
        end else if (bankWe) begin
            bank_r[wrIdx] <= shift_r;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seenWrite_r <= 1'b0;
        end else if (bankWe) begin
            seenWrite_r <= 1'b1;
        end
    end

    for (genvar g = 0; g < soeb_pkg::BANK_BYTES; g++) begin : g_read
        assign regBank[g*8 +: 8] = bank_r[g];
    end

    ////////////////////////////////////////////////////////////////////////
    // Output gating: cleared bit forces the output low

    logic [7:0] busLo;
    logic [7:0] mixed;
    logic [7:0] mid;

    assign busLo = bank_r[soeb_pkg::REG_BUS_LOW];
    assign mixed = bank_r[soeb_pkg::REG_MIXED];
    assign mid   = bank_r[soeb_pkg::REG_MID];

    // Enables change only on a completed byte, so gating is glitch bounded
    assign bus_clk_out_0  = busClkSrc & busLo[7];
    assign bus_clk_out_1  = busClkSrc & busLo[6];
    assign bus_clk_out_2  = busClkSrc & busLo[5];
    assign bus_clk_out_3  = busClkSrc & busLo[4];
    assign bus_clk_out_4  = busClkSrc & busLo[3];
    assign bus_clk_out_5  = busClkSrc & busLo[2];
    assign bus_clk_out_6  = busClkSrc & busLo[1];
    assign bus_clk_out_7  = busClkSrc & busLo[0];
    assign bus_clk_out_8  = busClkSrc & mixed[soeb_pkg::MIX_BUS_TOP];
    assign bus_clk_out_9  = busClkSrc & mixed[soeb_pkg::MIX_BUS_TOP-1];
    assign bus_clk_out_10 = busClkSrc & mixed[soeb_pkg::MIX_BUS_TOP-2];
    assign bus_clk_out_11 = busClkSrc & mixed[soeb_pkg::MIX_BUS_TOP-3];
    assign clk48_out_a    = clk48Src & mixed[soeb_pkg::MIX_48_A];
    assign clk48_out_b    = clk48Src & mixed[soeb_pkg::MIX_48_B];
    assign ref_clk_out_a  = refClkSrc & mixed[soeb_pkg::MIX_REF_A];
    assign ref_clk_out_b  = refClkSrc & mixed[soeb_pkg::MIX_REF_B];
    assign clk66_out_a    = clk66Src & mid[soeb_pkg::MID_66_TOP];
    assign clk66_out_b    = clk66Src & mid[soeb_pkg::MID_66_TOP-1];
    assign clk66_out_c    = clk66Src & mid[soeb_pkg::MID_66_TOP-2];
    assign clk66_out_d    = clk66Src & mid[soeb_pkg::MID_66_TOP-3];
    assign clk66_out_e    = clk66Src & mid[soeb_pkg::MID_66_TOP-4];
    assign clk66_out_f    = clk66Src & mid[soeb_pkg::MID_66_TOP-5];
    // Bytes 3, 4 and mid bits 1:0 feed nothing

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    logic [21:0] enVec;
    assign enVec = {busLo, mixed, mid[7:2]};

    powerUp_a: assert property (!seenWrite_r |-> enVec == '1 &&
                                regBank == soeb_pkg::BANK_RESET)
        else $error("enables not all set before first write");

    msbFirst_a: assert property (state_r == soeb_pkg::SOEB_RECV && sclRise &&
        !startSeen && !stopSeen |=> shift_r[0] == $past(sdaLvl) &&
        shift_r[7:1] == $past(shift_r[6:0]))
        else $error("serial bit not shifted in msb first");

    reservedQuiet_a: assert property (bankWe &&
        wrIdx >= soeb_pkg::REG_RSVD_THREE |=> $stable(enVec))
        else $error("reserved byte write changed an enable");

    readBack_a: assert property (bankWe |=>
        regBank[$past(wrIdx)*8 +: 8] == $past(shift_r))
        else $error("bank did not keep last written byte");

    gateLow_a: assert property (!busLo[7] |-> !bus_clk_out_0 &&
        (mid[2] || !clk66_out_f) && (mixed[0] || !ref_clk_out_b))
        else $error("disabled output not held low");

    busMap_a: assert property (busLo[0] |->
        bus_clk_out_7 == busClkSrc)
        else $error("byte zero bit zero does not pass bus output seven");

    mixMap_a: assert property (mixed[3] && mixed[4] |->
        clk48_out_a == clk48Src && bus_clk_out_11 == busClkSrc)
        else $error("mixed byte mapping wrong");

    midMap_a: assert property (mid[7] |->
        clk66_out_a == clk66Src)
        else $error("mid byte bit seven does not pass 66 output a");

    headerAck_a: assert property (byteDone &&
        byteIdx_r != soeb_pkg::IDX_ADDR |=> serialDataOe &&
        state_r == soeb_pkg::SOEB_ACK)
        else $error("command or data byte not acknowledged");

    dropExtra_a: assert property (byteDone &&
        byteIdx_r >= soeb_pkg::IDX_DATA_FIRST + 6'(soeb_pkg::BANK_BYTES)
        |=> regBank == $past(regBank))
        else $error("byte beyond the bank altered it");

    onlyWhole_a: assert property (!bankWe |=>
        regBank == $past(regBank))
        else $error("bank changed without a whole received byte");

    firstByte_c: cover property (bankWe && wrIdx == soeb_pkg::REG_BUS_LOW);
    lastByte_c:  cover property (bankWe && wrIdx == soeb_pkg::REG_RSVD_SUPPLY);
    addrNak_c:   cover property (state_r == soeb_pkg::SOEB_SKIP);
    stop_c:      cover property (seenWrite_r && stopSeen);

endmodule

/* File: soeb_host_model.sv */
/*
 * Behavioural two-wire host that writes configuration bytes to the bank.
 * Assumes a pull-up on the data line, so released means high; the link
 * clock stands high between frames and is paced by the core clock.
 */
module soeb_host_model (
    // Core clock used only for pacing
    input  wire logic clock,
    // Resolved data line
    input  wire logic sdaLine,
    // Link drive
    output logic      serialClk,
    output logic      hostLow,
    // Per-byte report
    output logic      ackSeen,
    output logic      byteDone
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        serialClk = 1'b1;
        hostLow   = 1'b0;
        ackSeen   = 1'b0;
        byteDone  = 1'b0;
    end

    task automatic waitCycles(input int n);
        repeat (n) @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Frame conditions, clock high while data moves

    task automatic startCond();
        hostLow = 1'b1;
        waitCycles(4);
        serialClk = 1'b0;
        waitCycles(2);
    endtask

    task automatic stopCond();
        hostLow = 1'b1;
        waitCycles(2);
        serialClk = 1'b1;
        waitCycles(2);
        hostLow = 1'b0;
        waitCycles(4);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One byte and its acknowledge, 160 ns per bit

    task automatic sendByte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            hostLow = ~b[i];
            waitCycles(2);
            serialClk = 1'b1;
            waitCycles(4);
            serialClk = 1'b0;
            waitCycles(2);
        end
        hostLow = 1'b0;
        waitCycles(2);
        serialClk = 1'b1;
        // Late in the high phase: the device answers through a synchroniser
        waitCycles(3);
        ackSeen  = ~sdaLine;
        byteDone = 1'b1;
        waitCycles(1);
        serialClk = 1'b0;
        byteDone  = 1'b0;
        waitCycles(2);
    endtask
endmodule

/* File: soeb_bank_tb_top.sv */
/*
 * Testbench for the serial output enable bank: host model writes frames,
 * a monitor compares acknowledge, bank and gated outputs at each byte.
 * Assumes a 50 MHz core clock and free-running random clock sources.
 */
module soeb_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        rstn;
    logic        busClkSrc;
    logic        clk48Src;
    logic        clk66Src;
    logic        refClkSrc;
    logic        serialClk;
    logic        hostLow;
    logic        ackSeen;
    logic        byteDone;
    logic        serialDataOut;
    logic        serialDataOe;
    logic [39:0] regBank;
    logic [21:0] outs;
    logic [39:0] expBank;
    logic [40:0] note;
    logic [7:0]  dat [8];
    logic [40:0] noteQ [$];
    int          fail_count = 0;
    int          check_count = 0;
    wire logic   sdaLine;
    localparam logic [7:0] ADDR_OK = {soeb_pkg::SLAVE_ADDR_DEF, 1'b0};
    localparam logic [39:0] BANK_PUP = 40'h0000FCFFFF;

    // Open-drain line: either party may pull low, pull-up otherwise
    assign sdaLine = hostLow ? 1'b0 : (serialDataOe ? serialDataOut : 1'b1);

    soeb_host_model host (.clock(clock), .sdaLine(sdaLine),
        .serialClk(serialClk), .hostLow(hostLow), .ackSeen(ackSeen),
        .byteDone(byteDone));

    soeb_bank dut (.clock(clock), .rstn(rstn), .serialClk(serialClk),
        .serialDataIn(sdaLine), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .busClkSrc(busClkSrc),
        .clk48Src(clk48Src), .clk66Src(clk66Src), .refClkSrc(refClkSrc),
        .bus_clk_out_0(outs[21]), .bus_clk_out_1(outs[20]),
        .bus_clk_out_2(outs[19]), .bus_clk_out_3(outs[18]),
        .bus_clk_out_4(outs[17]), .bus_clk_out_5(outs[16]),
        .bus_clk_out_6(outs[15]), .bus_clk_out_7(outs[14]),
        .bus_clk_out_8(outs[13]), .bus_clk_out_9(outs[12]),
        .bus_clk_out_10(outs[11]), .bus_clk_out_11(outs[10]),
        .clk48_out_a(outs[9]), .clk48_out_b(outs[8]),
        .clk66_out_a(outs[7]), .clk66_out_b(outs[6]),
        .clk66_out_c(outs[5]), .clk66_out_d(outs[4]),
        .clk66_out_e(outs[3]), .clk66_out_f(outs[2]),
        .ref_clk_out_a(outs[1]), .ref_clk_out_b(outs[0]),
        .regBank(regBank));

    ////////////////////////////////////////////////////////////////////////
    // Checking

    function automatic logic [21:0] expOut(logic [39:0] b, logic [3:0] s);
        logic [21:0] en;
        logic [21:0] src;
        en  = {b[7:0], b[15:10], b[23:18], b[9:8]};
        src = {{12{s[3]}}, {2{s[2]}}, {6{s[1]}}, {2{s[0]}}};
        return en & src;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clock) begin
        if (byteDone === 1'b1) begin
            if (noteQ.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                note = noteQ.pop_front();
                check(64'(ackSeen), 64'(note[40]));
                check(64'(regBank), 64'(note[39:0]));
                check(64'(outs), 64'(expOut(note[39:0], {busClkSrc,
                    clk48Src, clk66Src, refClkSrc})));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stimulus

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(negedge clock)
        {busClkSrc, clk48Src, clk66Src, refClkSrc} <= 4'($urandom);

    task automatic sendNoted(input logic [7:0] b, input logic ack);
        noteQ.push_back({ack, expBank});
        host.sendByte(b);
    endtask

    task automatic frame(input logic [7:0] addr, input int n,
                         input logic ok);
        host.startCond();
        sendNoted(addr, ok);
        if (ok) begin
            sendNoted(8'($urandom), 1'b1);
            sendNoted(8'(n), 1'b1);
            for (int k = 0; k < n; k++) begin
                if (k < 5)
                    expBank[8*k +: 8] = dat[k];
                sendNoted(dat[k], 1'b1);
            end
        end
        host.stopCond();
    endtask

    task automatic fill(input logic zeroRsvd);
        foreach (dat[i]) dat[i] = 8'($urandom);
        if (zeroRsvd) begin
            dat[2][1:0] = 2'h0;
            dat[3] = 8'h00;
            dat[4] = 8'h00;
        end
    endtask

    task automatic doReset();
        rstn = 1'b0;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        expBank = BANK_PUP;
        @(posedge clock);
        #1;
        check(64'(regBank), 64'(expBank));
        check(64'(outs), 64'(expOut(expBank, {busClkSrc, clk48Src,
            clk66Src, refClkSrc})));
        repeat (4) @(negedge clock);
    endtask

    initial begin
        void'($urandom(32'h2a474f46));
        {busClkSrc, clk48Src, clk66Src, refClkSrc} = 4'h0;
        expBank = BANK_PUP;
        doReset();
        frame(ADDR_OK ^ 8'h02, 0, 1'b0);
        frame(ADDR_OK | 8'h01, 0, 1'b0);
        // First pass leaves junk in reserved bits on purpose
        for (int i = 0; i < 4; i++) begin
            fill(i != 0);
            frame(ADDR_OK, 5, 1'b1);
        end
        fill(1'b1);
        frame(ADDR_OK, 2, 1'b1);
        fill(1'b1);
        frame(ADDR_OK, 7, 1'b1);
        foreach (dat[i]) dat[i] = 8'h00;
        frame(ADDR_OK, 3, 1'b1);
        doReset();
        fill(1'b1);
        frame(ADDR_OK, 1, 1'b1);
        repeat (20) @(negedge clock);
        check(64'(noteQ.size()), 64'h0);
        end_of_test();
    end

    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
endmodule
